// *** shared/serial_port_pkg.sv ***
// Constants, field positions and state types of the serial port controller.
package serial_port_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int BAUD_TABLE [8] = '{1200, 2400, 9600, 19200, 33600, 38400, 57600, 115200};
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATION = 8'h04;
	localparam logic [7:0] OFS_RTS = 8'h08;
	localparam logic [7:0] OFS_TMO = 8'h0C;
	localparam logic [7:0] OFS_DLY = 8'h10;
	localparam logic [7:0] OFS_PRESC = 8'h14;
	localparam logic [7:0] OFS_TXDATA = 8'h18;
	localparam logic [7:0] OFS_RXDATA = 8'h1C;
	localparam logic [7:0] OFS_STATUS = 8'h20;
	localparam logic [7:0] OFS_RESULT = 8'h24;
	localparam logic [7:0] OFS_CMD = 8'h28;
	localparam int CTRL_PROTO = 0;
	localparam int CTRL_PARITY = 2;
	localparam int CTRL_DATA8 = 4;
	localparam int CTRL_STOP2 = 5;
	localparam int CTRL_FULL = 6;
	localparam int CTRL_RS485 = 7;
	localparam int CTRL_SERVER = 8;
	localparam int CTRL_BAUD = 9;
	localparam int TX_LAST = 8;
	localparam int ST_TXBUSY = 0;
	localparam int ST_RXVALID = 1;
	localparam int ST_FRAME = 2;
	localparam int ST_PARITY = 3;
	localparam int ST_TIMEOUT = 4;
	localparam int ST_HEARTBEAT = 5;
	localparam int ST_DISCARD = 6;
	localparam int ST_EXCEPT = 7;
	localparam logic [31:0] CTRL_RST = 32'h0000_0010;
	localparam logic [7:0] STATION_RST = 8'h01;
	localparam logic [15:0] PRESC_RST = 16'h0031;
	localparam logic [7:0] STATION_MIN = 8'h01;
	localparam logic [7:0] STATION_MAX = 8'hF7;
	localparam logic [7:0] ERR_FUNC = 8'h01;
	localparam logic [7:0] ERR_ADDR = 8'h02;
	localparam logic [7:0] ERR_DATA = 8'h03;
	localparam logic [7:0] ERR_FAIL = 8'h04;
	localparam logic [7:0] ERR_BUSY = 8'h06;
	typedef enum logic [1:0] {PROTO_RTU = 2'b00, PROTO_ASCII = 2'b01,
		PROTO_CUSTOM = 2'b10} proto_type;
	typedef enum logic [1:0] {PAR_NONE = 2'b00, PAR_EVEN = 2'b01, PAR_ODD = 2'b10} parity_type;
	typedef enum logic [2:0] {TX_IDLE = 3'b000, TX_RTS_ON = 3'b001, TX_SHIFT = 3'b010,
		TX_RTS_OFF = 3'b011} tx_state_type;
	typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10} rx_state_type;
endpackage

// *** verilog/serial_port_rtu_ascii_controller.sv ***
// Serial port controller for Modbus RTU, ASCII and custom traffic with an APB register file.
//
// Notes on behaviour
// - RTU server answers own station, 1 to 247.
// - Parity none, even or odd.
// - Seven or eight bits; RTU forces eight.
// - One or two stop bits.
// - Half duplex never sends and receives together.
// - Full duplex only outside RTU mode.
// - Outside RS-485, RTS held for off delay after sending.
// - Outside RS-485, RTS raised, on delay, then first character.
// - Client times reply; timeout status on expiry.
// - In RTU, gap over character timeout discards partial message.
// - RS-485 RTU server waits response delay before replying.
// - RS-485 RTU client waits request delay before requesting.
// - Reply delay applies only on RS-485.
// - Heartbeat timer restarts per packet, flags expiry.
// - Error codes only for client transactions.
// - Error code written to request result location.
// - Codes 01 function, 02 address, 03 data.
// - Codes 04 device failure, 06 busy.
// - Eight selectable bit rates, 1200 to 115200.
// - Protocol modes RTU, ASCII or custom.
`timescale 1ns/1ps
module serial_port_rtu_ascii_controller (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial line
	input wire logic rxd,
	output logic txd,
	output logic rts
);
	logic [31:0] ctrl, rts_dly, tmo, dly;
	logic [15:0] presc, presc_cnt;
	logic [7:0] station, result_code, result_tag, rx_data, tx_hold, msg_cnt;
	logic [7:2] st;
	logic rx_valid, tx_pend, tx_last, tx_msg_end, s1, s2, s3, rx_f, addr_match, exc_pend;
	logic wait_rsp;
	serial_port_pkg::tx_state_type tx_state;
	serial_port_pkg::rx_state_type rx_state;
	logic [15:0] tx_tmr, rx_tmr, tx_cnt, gap_cnt, rsp_cnt, hb_cnt, turn_cnt;
	logic [11:0] tx_sh;
	logic [10:0] rx_sh;
	logic [3:0] tx_bits, rx_idx;

	function automatic logic [15:0] bit_period(input logic [2:0] sel);
		bit_period = 16'(serial_port_pkg::CLK_HZ / serial_port_pkg::BAUD_TABLE[sel]);
	endfunction

	// Start bit at index 0, data LSB first, then parity; spare positions stay one as stop bits.
	function automatic logic [11:0] char_frame(input logic [7:0] d, input logic d8,
			input logic [1:0] par);
		logic [11:0] f;
		f = 12'hFFF;
		f[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i < 7 || d8) begin
				f[i + 1] = d[i];
			end
		end
		if (par == serial_port_pkg::PAR_EVEN) begin
			f[d8 ? 9 : 8] = ^(d8 ? d : {1'b0, d[6:0]});
		end else if (par == serial_port_pkg::PAR_ODD) begin
			f[d8 ? 9 : 8] = ~^(d8 ? d : {1'b0, d[6:0]});
		end
		return f;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = a == serial_port_pkg::OFS_CTRL || a == serial_port_pkg::OFS_STATION ||
			a == serial_port_pkg::OFS_RTS || a == serial_port_pkg::OFS_TMO ||
			a == serial_port_pkg::OFS_DLY || a == serial_port_pkg::OFS_PRESC ||
			a == serial_port_pkg::OFS_TXDATA || a == serial_port_pkg::OFS_RXDATA ||
			a == serial_port_pkg::OFS_STATUS || a == serial_port_pkg::OFS_RESULT ||
			a == serial_port_pkg::OFS_CMD;
	endfunction

	function automatic logic [7:0] exc_map(input logic [7:0] c);
		case (c)
			serial_port_pkg::ERR_FUNC, serial_port_pkg::ERR_ADDR, serial_port_pkg::ERR_DATA,
			serial_port_pkg::ERR_FAIL, serial_port_pkg::ERR_BUSY: exc_map = c;
			default: exc_map = serial_port_pkg::ERR_FAIL;
		endcase
	endfunction

	// Decoded configuration.
	logic is_rtu, d8, half, rs485, server, station_ok, tick, tx_active, rx_active;
	logic [1:0] par;
	logic [3:0] nbits, dbits, pbit;
	logic [15:0] bp;
	assign is_rtu = ctrl[serial_port_pkg::CTRL_PROTO +: 2] == serial_port_pkg::PROTO_RTU;
	assign d8 = ctrl[serial_port_pkg::CTRL_DATA8] | is_rtu;
	assign half = ~ctrl[serial_port_pkg::CTRL_FULL] | is_rtu;
	assign rs485 = ctrl[serial_port_pkg::CTRL_RS485];
	assign server = ctrl[serial_port_pkg::CTRL_SERVER];
	assign par = ctrl[serial_port_pkg::CTRL_PARITY +: 2];
	assign station_ok = station >= serial_port_pkg::STATION_MIN &&
		station <= serial_port_pkg::STATION_MAX;
	assign dbits = d8 ? 4'd8 : 4'd7;
	assign pbit = par == serial_port_pkg::PAR_NONE ? 4'd0 : 4'd1;
	assign nbits = 4'd2 + dbits + pbit + {3'd0, ctrl[serial_port_pkg::CTRL_STOP2]};
	assign bp = bit_period(ctrl[serial_port_pkg::CTRL_BAUD +: 3]);
	assign tx_active = tx_state != serial_port_pkg::TX_IDLE;
	assign rx_active = rx_state != serial_port_pkg::RX_IDLE;

	// APB: zero wait states; read data is captured in the setup cycle.
	logic wr, rd, rx_done;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped(paddr);
	assign wr = psel & penable & pwrite & mapped(paddr);
	assign rd = psel & penable & ~pwrite;
	assign rx_done = wr && paddr == serial_port_pkg::OFS_CMD && pwdata[0];

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ctrl <= serial_port_pkg::CTRL_RST;
			station <= serial_port_pkg::STATION_RST;
			rts_dly <= 32'h0000_0000;
			tmo <= 32'h0000_0000;
			dly <= 32'h0000_0000;
			presc <= serial_port_pkg::PRESC_RST;
		end else if (wr) begin
			case (paddr)
				serial_port_pkg::OFS_CTRL: ctrl <= {20'h0_0000, pwdata[11:0]};
				serial_port_pkg::OFS_STATION: station <= pwdata[7:0];
				serial_port_pkg::OFS_RTS: rts_dly <= pwdata;
				serial_port_pkg::OFS_TMO: tmo <= pwdata;
				serial_port_pkg::OFS_DLY: dly <= pwdata;
				serial_port_pkg::OFS_PRESC: presc <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			case (paddr)
				serial_port_pkg::OFS_CTRL: prdata <= ctrl;
				serial_port_pkg::OFS_STATION: prdata <= {24'h00_0000, station};
				serial_port_pkg::OFS_RTS: prdata <= rts_dly;
				serial_port_pkg::OFS_TMO: prdata <= tmo;
				serial_port_pkg::OFS_DLY: prdata <= dly;
				serial_port_pkg::OFS_PRESC: prdata <= {16'h0000, presc};
				serial_port_pkg::OFS_RXDATA: prdata <= {23'h00_0000, rx_valid, rx_data};
				serial_port_pkg::OFS_STATUS: prdata <= {24'h00_0000, st, rx_valid,
					tx_pend | tx_active};
				serial_port_pkg::OFS_RESULT: prdata <= {16'h0000, result_tag, result_code};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Prescaler tick shared by every delay and timeout counter.
	always_ff @(posedge clk_sys) begin
		if (!nrst || presc_cnt >= presc) begin
			presc_cnt <= 16'h0000;
		end else begin
			presc_cnt <= presc_cnt + 16'h0001;
		end
	end
	assign tick = presc_cnt >= presc;

	// Transmitter.
	logic tx_load, tx_char_end, tx_go, query_sent;
	assign tx_char_end = tx_state == serial_port_pkg::TX_SHIFT && tx_tmr == bp - 16'h0001 &&
		tx_bits == 4'd1;
	assign tx_go = tx_pend && turn_cnt == 16'h0000 && !(half && rx_active);
	assign tx_load = (tx_state == serial_port_pkg::TX_IDLE && tx_go &&
			(rs485 || rts_dly[15:0] == 16'h0000)) ||
		(tx_state == serial_port_pkg::TX_RTS_ON && tick && turn_cnt == 16'h0000 &&
			tx_cnt + 16'h0001 >= rts_dly[15:0]) ||
		(tx_char_end && tx_pend && turn_cnt == 16'h0000);
	assign query_sent = tx_char_end && tx_msg_end && !server;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			tx_pend <= 1'b0;
			tx_hold <= 8'h00;
			tx_last <= 1'b0;
		end else if (wr && paddr == serial_port_pkg::OFS_TXDATA && !tx_pend) begin
			tx_pend <= 1'b1;
			tx_hold <= pwdata[7:0];
			tx_last <= pwdata[serial_port_pkg::TX_LAST];
		end else if (tx_load) begin
			tx_pend <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			tx_state <= serial_port_pkg::TX_IDLE;
			tx_sh <= 12'hFFF;
			tx_bits <= 4'd0;
			tx_tmr <= 16'h0000;
			tx_cnt <= 16'h0000;
			tx_msg_end <= 1'b0;
			rts <= 1'b0;
		end else if (tx_load) begin
			tx_state <= serial_port_pkg::TX_SHIFT;
			tx_sh <= char_frame(tx_hold, d8, par);
			tx_bits <= nbits;
			tx_tmr <= 16'h0000;
			tx_msg_end <= tx_last;
			rts <= 1'b1;
		end else begin
			case (tx_state)
				serial_port_pkg::TX_IDLE: begin
					tx_cnt <= 16'h0000;
					if (tx_go) begin
						tx_state <= serial_port_pkg::TX_RTS_ON;
						rts <= 1'b1;
					end
				end
				serial_port_pkg::TX_RTS_ON: begin
					if (tick) begin
						tx_cnt <= tx_cnt + 16'h0001;
					end
				end
				serial_port_pkg::TX_SHIFT: begin
					if (tx_tmr == bp - 16'h0001) begin
						tx_tmr <= 16'h0000;
						tx_sh <= {1'b1, tx_sh[11:1]};
						tx_bits <= tx_bits - 4'd1;
						if (tx_bits == 4'd1) begin
							tx_cnt <= 16'h0000;
							if (rs485 || rts_dly[31:16] == 16'h0000) begin
								tx_state <= serial_port_pkg::TX_IDLE;
								rts <= 1'b0;
							end else begin
								tx_state <= serial_port_pkg::TX_RTS_OFF;
							end
						end
					end else begin
						tx_tmr <= tx_tmr + 16'h0001;
					end
				end
				serial_port_pkg::TX_RTS_OFF: begin
					if (tick) begin
						tx_cnt <= tx_cnt + 16'h0001;
						if (tx_cnt + 16'h0001 >= rts_dly[31:16]) begin
							tx_state <= serial_port_pkg::TX_IDLE;
							rts <= 1'b0;
						end
					end
				end
				default: tx_state <= serial_port_pkg::TX_IDLE;
			endcase
		end
	end
	assign txd = tx_state == serial_port_pkg::TX_SHIFT ? tx_sh[0] : 1'b1;

	// Receiver: a level change counts once the second and third stages agree.
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
			rx_f <= 1'b1;
		end else begin
			s1 <= rxd;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				rx_f <= s3;
			end
		end
	end

	logic rx_byte, perr, ferr, deliver, gap_over;
	logic [7:0] rx_char;
	logic [11:0] rx_exp;
	logic [3:0] sp;
	assign rx_byte = rx_state == serial_port_pkg::RX_DATA && rx_tmr == bp - 16'h0001 &&
		rx_idx == nbits - 4'd2;
	assign rx_char = 8'({rx_f, rx_sh} >> (4'd13 - nbits)) & {d8, 7'h7F};
	assign sp = dbits + pbit;
	always_comb begin
		rx_exp = char_frame(rx_char, d8, par);
		// Parity sits just below the stop bits, whose place depends on the stop count.
		perr = pbit != 4'd0 && (ctrl[serial_port_pkg::CTRL_STOP2] ? rx_sh[9] : rx_sh[10])
			!= rx_exp[sp];
		ferr = !rx_f || (ctrl[serial_port_pkg::CTRL_STOP2] && !rx_sh[10]);
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			rx_state <= serial_port_pkg::RX_IDLE;
			rx_tmr <= 16'h0000;
			rx_idx <= 4'd0;
			rx_sh <= 11'h7FF;
		end else begin
			case (rx_state)
				serial_port_pkg::RX_IDLE: begin
					rx_tmr <= 16'h0000;
					rx_idx <= 4'd0;
					if (!rx_f && !(half && (tx_active || tx_go))) begin
						rx_state <= serial_port_pkg::RX_START;
					end
				end
				serial_port_pkg::RX_START: begin
					rx_tmr <= rx_tmr + 16'h0001;
					if (rx_tmr == {1'b0, bp[15:1]}) begin
						rx_tmr <= 16'h0000;
						rx_state <= rx_f ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
					end
				end
				serial_port_pkg::RX_DATA: begin
					rx_tmr <= rx_tmr + 16'h0001;
					if (rx_tmr == bp - 16'h0001) begin
						rx_tmr <= 16'h0000;
						rx_sh <= {rx_f, rx_sh[10:1]};
						rx_idx <= rx_idx + 4'd1;
						if (rx_byte) begin
							rx_state <= serial_port_pkg::RX_IDLE;
						end
					end
				end
				default: rx_state <= serial_port_pkg::RX_IDLE;
			endcase
		end
	end

	// Message tracking. The shift register is right aligned only for the longest frame,
	// so the character is realigned by the frame length before use.
	logic [7:0] rx_word;
	assign rx_word = rx_char;
	assign gap_over = is_rtu && msg_cnt != 8'h00 && gap_cnt > tmo[31:16];
	assign deliver = rx_byte && !ferr && !perr && (!is_rtu || !server ||
		(msg_cnt == 8'h00 ? rx_word == station && station_ok : addr_match));

	always_ff @(posedge clk_sys) begin
		if (!nrst || rx_done || gap_over) begin
			msg_cnt <= 8'h00;
			gap_cnt <= 16'h0000;
			addr_match <= 1'b0;
			exc_pend <= 1'b0;
		end else if (rx_byte) begin
			gap_cnt <= 16'h0000;
			msg_cnt <= msg_cnt == 8'hFF ? msg_cnt : msg_cnt + 8'h01;
			if (msg_cnt == 8'h00) begin
				addr_match <= rx_word == station && station_ok;
			end
			if (msg_cnt == 8'h01) begin
				exc_pend <= rx_word[7];
			end
		end else if (tick && msg_cnt != 8'h00) begin
			gap_cnt <= gap_cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			rx_valid <= 1'b0;
			rx_data <= 8'h00;
		end else if (deliver) begin
			rx_valid <= 1'b1;
			rx_data <= rx_word;
		end else if (rd && paddr == serial_port_pkg::OFS_RXDATA) begin
			rx_valid <= 1'b0;
		end
	end

	// Client exception code, tagged with the request that software names.
	logic exc_set;
	assign exc_set = rx_byte && is_rtu && !server && msg_cnt == 8'h02 && exc_pend;
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			result_code <= 8'h00;
			result_tag <= 8'h00;
		end else if (exc_set) begin
			result_code <= exc_map(rx_word);
		end else if (wr && paddr == serial_port_pkg::OFS_RESULT) begin
			result_tag <= pwdata[15:8];
			result_code <= 8'h00;
		end
	end

	// Reply timeout, turnaround delay and heartbeat, all in prescaled ticks.
	logic tmo_set, hb_set;
	assign tmo_set = wait_rsp && tick && rsp_cnt + 16'h0001 >= tmo[15:0];
	assign hb_set = dly[31:16] != 16'h0000 && tick && hb_cnt + 16'h0001 == dly[31:16];
	always_ff @(posedge clk_sys) begin
		if (!nrst || rx_done || tmo_set) begin
			wait_rsp <= 1'b0;
			rsp_cnt <= 16'h0000;
		end else if (query_sent) begin
			wait_rsp <= 1'b1;
			rsp_cnt <= 16'h0000;
		end else if (wait_rsp && tick) begin
			rsp_cnt <= rsp_cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			turn_cnt <= 16'h0000;
		end else if (rx_done) begin
			turn_cnt <= rs485 && is_rtu ? dly[15:0] : 16'h0000;
		end else if (tick && turn_cnt != 16'h0000) begin
			turn_cnt <= turn_cnt - 16'h0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst || rx_done || dly[31:16] == 16'h0000) begin
			hb_cnt <= 16'h0000;
		end else if (tick && hb_cnt != dly[31:16]) begin
			hb_cnt <= hb_cnt + 16'h0001;
		end
	end

	// Sticky status: a hardware set in the same cycle as a clear wins.
	logic [7:2] st_set;
	assign st_set = {exc_set, gap_over, hb_set, tmo_set, rx_byte && perr, rx_byte && ferr};
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			st <= 6'h00;
		end else if (wr && paddr == serial_port_pkg::OFS_STATUS) begin
			st <= (st & ~pwdata[7:2]) | st_set;
		end else begin
			st <= st | st_set;
		end
	end

	sequence s_rts_rise;
		$rose(rts) && !rs485 && rts_dly[15:0] > 16'h0001;
	endsequence
	sequence s_line_idle2;
		txd [*2];
	endsequence
	a_rts_on_wait: assert property (@(posedge clk_sys) disable iff (!nrst)
		s_rts_rise |-> s_line_idle2) else $error("data sent before on delay");
	a_rts_off_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
		tx_state == serial_port_pkg::TX_RTS_OFF |-> rts && txd) else $error("rts dropped early");
	a_half_duplex: assert property (@(posedge clk_sys) disable iff (!nrst)
		half && tx_state == serial_port_pkg::TX_SHIFT |-> !rx_active) else $error("half duplex clash");
	a_rtu_eight_bits: assert property (@(posedge clk_sys) disable iff (!nrst)
		tx_load && is_rtu |=> tx_bits >= 4'd10) else $error("rtu frame too short");
	a_station_filter: assert property (@(posedge clk_sys) disable iff (!nrst)
		rx_byte && is_rtu && server && msg_cnt == 8'h00 && !station_ok |=> !$rose(rx_valid))
		else $error("bad station accepted");
	a_gap_discard: assert property (@(posedge clk_sys) disable iff (!nrst)
		gap_over |=> msg_cnt == 8'h00) else $error("partial message kept");
	a_turn_wait: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(tx_state == serial_port_pkg::TX_SHIFT) |-> $past(turn_cnt) == 16'h0000)
		else $error("turnaround delay skipped");
	a_client_codes: assert property (@(posedge clk_sys) disable iff (!nrst)
		$changed(result_code) && result_code != 8'h00 |-> !server) else $error("server code");
	a_heartbeat: assert property (@(posedge clk_sys) disable iff (!nrst)
		$rose(st[serial_port_pkg::ST_HEARTBEAT]) |-> dly[31:16] != 16'h0000)
		else $error("heartbeat without period");
endmodule

// *** bench/serial_peer_model.sv ***
// Behavioural model of the serial device at the far end of the line.
`timescale 1ns/1ps
module serial_peer_model #(
	parameter int BIT = 434
) (
	// Clock
	input wire logic clk_sys,
	// Line from the controller
	input wire logic txd,
	input wire logic rts,
	// Line to the controller
	output logic rxd
);
	logic [7:0] got = 8'h00;
	int n_got = 0;
	int lead = 0;
	time t_rts = 0;

	// The line starts high and each frame ends on a high stop bit, so it idles high between frames.
	initial rxd = 1'b1;

	// Sends one character; callers wait ten clocks after each frame before the next.
	task automatic send(input logic [7:0] b, input serial_port_pkg::parity_type par,
		input logic bad);
		logic [10:0] f;
		int n;
		f = {1'b1, ^b ^ (par == serial_port_pkg::PAR_ODD) ^ bad, b, 1'b0};
		n = (par == serial_port_pkg::PAR_NONE) ? 10 : 11;
		if (par == serial_port_pkg::PAR_NONE) begin
			f[9] = 1'b1;
		end
		for (int i = 0; i < n; i++) begin
			rxd <= f[i];
			repeat (BIT) @(posedge clk_sys);
		end
	endtask

	always @(posedge rts) t_rts = $time;

	// Samples mid-bit, LSB first; the tail is skipped so a low parity bit is no new start.
	always begin
		@(negedge txd);
		lead = int'(($time - t_rts) / 20);
		repeat (BIT / 2) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk_sys);
			got[i] = txd;
		end
		repeat (BIT) @(posedge clk_sys);
		n_got++;
	end
endmodule

// *** bench/serial_port_rtu_ascii_controller_tb.sv ***
// Self-checking bench for the serial port controller.
`timescale 1ns/1ps
module serial_port_rtu_ascii_controller_tb;
	localparam int BIT = serial_port_pkg::CLK_HZ / serial_port_pkg::BAUD_TABLE[7];
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rxd;
	logic txd;
	logic rts;
	int n_fail = 0;
	int checks = 0;
	logic [31:0] seed = 32'h0000_E9AB;
	logic [31:0] rd;
	logic [31:0] r;
	logic err;
	logic [7:0] b;
	logic [7:0] st;
	logic [7:0] codes [5] = '{serial_port_pkg::ERR_FUNC, serial_port_pkg::ERR_ADDR,
		serial_port_pkg::ERR_DATA, serial_port_pkg::ERR_FAIL, serial_port_pkg::ERR_BUSY};

	always #10 clk_sys = ~clk_sys;

	serial_port_rtu_ascii_controller serial_port_rtu_ascii_controller_inst (
		.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxd(rxd), .txd(txd), .rts(rts));

	serial_peer_model #(.BIT(BIT)) serial_peer_model_inst (
		.clk_sys(clk_sys), .txd(txd), .rts(rts), .rxd(rxd));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		if (n_fail == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer.
		do begin
			@(posedge clk_sys);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_got(input int n);
		for (int i = 0; i < 6000 && serial_peer_model_inst.n_got < n; i++) begin
			@(posedge clk_sys);
		end
		if (serial_peer_model_inst.n_got < n) begin
			n_fail++;
		end
	endtask

	task automatic rx_byte(input logic [7:0] v);
		serial_peer_model_inst.send(v, serial_port_pkg::PAR_NONE, 1'b0);
		repeat (10) @(posedge clk_sys);
	endtask

	initial begin
		repeat (100000) @(posedge clk_sys);
		n_fail++;
		close_out();
	end

	initial begin
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		apb(0, serial_port_pkg::OFS_CTRL, 0);
		chk(rd, serial_port_pkg::CTRL_RST);
		apb(0, serial_port_pkg::OFS_STATION, 0);
		chk(rd, 32'(serial_port_pkg::STATION_RST));
		apb(0, serial_port_pkg::OFS_PRESC, 0);
		chk(rd, 32'(serial_port_pkg::PRESC_RST));
		apb(0, 8'h3C, 0);
		chk({rd[30:0], err}, 32'h0000_0001);
		// One tick per clock keeps every delay short and exact.
		apb(1, serial_port_pkg::OFS_PRESC, 0);
		apb(1, serial_port_pkg::OFS_RTS, 32'h001E_0014);
		apb(1, serial_port_pkg::OFS_CTRL, 32'h0000_0E15);
		r = xs();
		b = r[7:0];
		apb(1, serial_port_pkg::OFS_TXDATA, 32'(b));
		wait_got(1);
		chk(32'(serial_peer_model_inst.got), 32'(b));
		chk(32'(serial_peer_model_inst.lead inside {[20:22]}), 1);
		repeat (BIT + BIT / 2 + 15) @(posedge clk_sys);
		chk(32'(rts), 1);
		repeat (45) @(posedge clk_sys);
		chk(32'(rts), 0);
		for (int p = 0; p < 3; p++) begin
			apb(1, serial_port_pkg::OFS_CTRL, 32'h0000_0E11 | 32'(p << 2));
			r = xs();
			b = r[7:0];
			serial_peer_model_inst.send(b, serial_port_pkg::parity_type'(p), 1'b0);
			repeat (10) @(posedge clk_sys);
			apb(0, serial_port_pkg::OFS_RXDATA, 0);
			chk(32'(rd[8:0]), 32'h0000_0100 | 32'(b));
		end
		serial_peer_model_inst.send(b, serial_port_pkg::PAR_ODD, 1'b1);
		repeat (10) @(posedge clk_sys);
		apb(0, serial_port_pkg::OFS_STATUS, 0);
		chk(32'(rd[serial_port_pkg::ST_PARITY]), 1);
		apb(0, serial_port_pkg::OFS_RXDATA, 0);
		chk(32'(rd[8]), 0);
		r = xs();
		st = 8'(r % 247 + 1);
		apb(1, serial_port_pkg::OFS_STATION, 32'(st));
		apb(1, serial_port_pkg::OFS_CTRL, 32'h0000_0F10);
		// A byte-to-byte gap limit above one character, and a clean message count.
		apb(1, serial_port_pkg::OFS_TMO, 32'h1800_0000);
		apb(1, serial_port_pkg::OFS_CMD, 1);
		rx_byte(st ^ 8'h01);
		apb(1, serial_port_pkg::OFS_CMD, 1);
		apb(0, serial_port_pkg::OFS_RXDATA, 0);
		chk(32'(rd[8]), 0);
		rx_byte(st);
		apb(0, serial_port_pkg::OFS_RXDATA, 0);
		chk(32'(rd[8:0]), 32'h0000_0100 | 32'(st));
		rx_byte(8'h83);
		rx_byte(serial_port_pkg::ERR_ADDR);
		apb(1, serial_port_pkg::OFS_CMD, 1);
		apb(0, serial_port_pkg::OFS_RESULT, 0);
		chk(32'(rd[7:0]), 0);
		apb(0, serial_port_pkg::OFS_RXDATA, 0);
		apb(1, serial_port_pkg::OFS_STATION, 0);
		rx_byte(8'h00);
		apb(1, serial_port_pkg::OFS_CMD, 1);
		apb(0, serial_port_pkg::OFS_RXDATA, 0);
		chk(32'(rd[8]), 0);
		apb(1, serial_port_pkg::OFS_CTRL, 32'h0000_0E10);
		for (int k = 0; k < 2; k++) begin
			r = xs();
			b = (k == 1) ? serial_port_pkg::ERR_BUSY : codes[r % 5];
			apb(1, serial_port_pkg::OFS_RESULT, 32'h0000_5A00);
			rx_byte(8'h11);
			rx_byte(8'h83);
			rx_byte(b);
			apb(1, serial_port_pkg::OFS_CMD, 1);
			apb(0, serial_port_pkg::OFS_RESULT, 0);
			chk(32'(rd[15:0]), 32'h0000_5A00 | 32'(b));
			apb(0, serial_port_pkg::OFS_STATUS, 0);
			chk(32'(rd[serial_port_pkg::ST_EXCEPT]), 1);
			apb(1, serial_port_pkg::OFS_STATUS, 32'h0000_0080);
		end
		apb(1, serial_port_pkg::OFS_TMO, 32'h0040_0064);
		rx_byte(8'h11);
		apb(0, serial_port_pkg::OFS_STATUS, 0);
		chk(32'(rd[serial_port_pkg::ST_DISCARD]), 1);
		apb(1, serial_port_pkg::OFS_TXDATA, 32'h0000_0100 | 32'(b));
		wait_got(2);
		repeat (BIT / 2 + 60) @(posedge clk_sys);
		apb(0, serial_port_pkg::OFS_STATUS, 0);
		chk(32'(rd[serial_port_pkg::ST_TIMEOUT]), 0);
		repeat (100) @(posedge clk_sys);
		apb(0, serial_port_pkg::OFS_STATUS, 0);
		chk(32'(rd[serial_port_pkg::ST_TIMEOUT]), 1);
		apb(1, serial_port_pkg::OFS_DLY, 32'h0064_0000);
		apb(1, serial_port_pkg::OFS_CMD, 1);
		repeat (50) @(posedge clk_sys);
		apb(0, serial_port_pkg::OFS_STATUS, 0);
		chk(32'(rd[serial_port_pkg::ST_HEARTBEAT]), 0);
		repeat (80) @(posedge clk_sys);
		apb(0, serial_port_pkg::OFS_STATUS, 0);
		chk(32'(rd[serial_port_pkg::ST_HEARTBEAT]), 1);
		close_out();
	end
endmodule
